//--- hdl/dsm_pkg.sv
/*
 Constants for the descriptor scan maps: register offsets, reset values,
 field positions and the scanner state encoding.
 Assumes a 12-bit byte address on a plain register port, 32-bit data.
*/
package dsm_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int DSM_AW    = 12;
   localparam int DSM_DW    = 32;
   localparam int DSM_NDESC = 32;
   localparam int DSM_IDXW  = 5;
   localparam int DSM_NCAT  = 2;
   localparam int DSM_CAT_ISO = 0;
   localparam int DSM_CAT_INT = 1;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] DSM_OFS_ISO_DONE_MAP = 12'h130;
   localparam logic [11:0] DSM_OFS_ISO_SKIP_MAP = 12'h134;
   localparam logic [11:0] DSM_OFS_ISO_LAST_MAP = 12'h138;
   localparam logic [11:0] DSM_OFS_INT_DONE_MAP = 12'h140;
   localparam logic [11:0] DSM_OFS_INT_SKIP_MAP = 12'h144;
   localparam logic [11:0] DSM_OFS_INT_LAST_MAP = 12'h148;
   localparam logic [11:0] DSM_OFS_SCAN_CTRL    = 12'h14c;
   localparam logic [11:0] DSM_OFS_SCAN_POS     = 12'h16c;
   localparam logic [11:0] DSM_OFS_IRQ_STATUS   = 12'h160;
   localparam logic [11:0] DSM_OFS_IRQ_ENABLE   = 12'h164;
   localparam logic [11:0] DSM_OFS_IRQ_CLEAR    = 12'h168;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] DSM_DONE_RST = 32'h0000_0000;
   localparam logic [31:0] DSM_SKIP_RST = 32'hffff_ffff;
   localparam logic [31:0] DSM_LAST_RST = 32'h0000_0000;
   localparam logic [1:0]  DSM_CTRL_RST = 2'h0;
   localparam logic [3:0]  DSM_IRQ_RST  = 4'h0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DSM_IRQ_W        = 4;  // Status, enable, clear width
   localparam int DSM_IRQ_DONE_LSB = 0;  // Done event, one bit per category
   localparam int DSM_IRQ_PASS_LSB = 2;  // Pass end, one bit per category
   localparam int DSM_POS_STRIDE   = 8;  // Scan position field per category
   localparam int DSM_RUN_LSB      = 16; // Scanner running, per category

   // Scanner state
   typedef enum logic {
      DSM_SC_IDLE = 1'b0,
      DSM_SC_RUN  = 1'b1
   } dsm_scan_state_t;

endpackage

//--- hdl/dsm_scan.sv
/*
 One category's descriptor scanner: walks descriptor positions, offers
 valid, unskipped ones to the engine and wraps after the final position.
 Assumes the engine runs on the same clock and answers accept in the cycle.
*/
`timescale 1ns/10ps
module dsm_scan #(
   parameter int NDESC = dsm_pkg::DSM_NDESC,
   parameter int IDXW  = dsm_pkg::DSM_IDXW
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   // Maps from the register file
   input  wire logic             run_i,
   input  wire logic [NDESC-1:0] skip_i,
   input  wire logic [NDESC-1:0] last_i,
   // Descriptor engine
   input  wire logic [NDESC-1:0] valid_i,
   input  wire logic             accept_i,
   input  wire logic             next_vld_i,
   input  wire logic [IDXW-1:0]  next_ptr_i,
   output logic                  issue_o,
   output logic [IDXW-1:0]       issue_idx_o,
   output logic                  running_o,
   output logic                  pass_o
);
   import dsm_pkg::*;

   dsm_scan_state_t state_r;
   dsm_scan_state_t state_nxt;
   logic [IDXW-1:0] pos_r;
   logic [IDXW-1:0] pos_nxt;
   logic [IDXW-1:0] final_idx;
   logic            pass_r;

   // ---------------------------------------------------------------
   // Position decode
   // ---------------------------------------------------------------
   wire running  = (state_r == DSM_SC_RUN);
   wire eligible = valid_i[pos_r] & ~skip_i[pos_r];     // [RL3]
   wire at_final = (pos_r == final_idx);                // [RL7]
   wire advance  = running & (~eligible | accept_i);
   // Only an offered descriptor's pointer counts, so a skipped one never steers
   wire jump     = running & eligible & accept_i & next_vld_i; // [RL4]

   // Highest set bit wins; an empty map means all positions
   always_comb begin
      final_idx = IDXW'(NDESC - 1);                     // [RL11]
      for (int i = 0; i < NDESC; i++) begin
         if (last_i[i]) begin
            final_idx = IDXW'(i);                       // [RL12] [RL9]
         end
      end
   end

   // Wrap to position zero after the final one
   assign pos_nxt = !running ? '0 :
                    !advance ? pos_r :
                    at_final ? '0 :                     // [RL8]
                    jump     ? next_ptr_i :
                               IDXW'(pos_r + 1'b1);

   // Run control
   always_comb begin
      case (state_r)
         DSM_SC_IDLE: state_nxt = run_i ? DSM_SC_RUN : DSM_SC_IDLE;
         DSM_SC_RUN:  state_nxt = run_i ? DSM_SC_RUN : DSM_SC_IDLE;
         default:     state_nxt = DSM_SC_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= DSM_SC_IDLE;
         pos_r   <= '0;
         pass_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pos_r   <= pos_nxt;
         pass_r  <= advance & at_final;
      end
   end

   assign issue_o     = running & eligible;             // [RL3]
   assign issue_idx_o = pos_r;
   assign running_o   = running;
   assign pass_o      = pass_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_skip_no_issue: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL3]
      running && skip_i[pos_r] |-> !issue_o)
      else $error("skipped descriptor was offered");

   a_skip_ptr_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL4]
      running && run_i && skip_i[pos_r] && !at_final |=> pos_r == IDXW'($past(pos_r) + 1'b1))
      else $error("skipped descriptor changed scan order");

   a_stop_at_last: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL7]
      running && run_i && at_final && !eligible |=> pos_r == '0 && pass_o)
      else $error("scan went past the final position");

   a_wrap_after_last: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL8]
      running && run_i && at_final && issue_o && accept_i |=> pos_r == '0 && pass_o)
      else $error("no restart at position zero");

   a_full_span: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL11]
      running && run_i && last_i == '0 && pos_r != IDXW'(NDESC - 1) && !eligible |=> pos_r != '0)
      else $error("empty last map wrapped early");

   a_final_highest: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL12]
      last_i != '0 |-> (last_i >> final_idx) == NDESC'(1))
      else $error("final position is not the highest set bit");

endmodule

//--- hdl/dsm_maps.sv
/*
 Done, skip and last-descriptor maps for the isochronous and interrupt
 categories, with their scanners, a plain register port and one interrupt.
 Assumes the descriptor engine shares sys_clk_i and drives its handshake
 and completion pulses from flip-flops on that clock.
*/
// Decided for this implementation: the strobed register port.
// Functional notes
// (RL1) Each done map has one bit per descriptor, 32 in all, set as soon as that descriptor completes.
// (RL2) Reading a done map returns its bits and clears those that were one, so the next read shows newer ones.
// (RL3) A descriptor whose skip bit is one is never processed, whatever its valid flag says.
// (RL4) The next-descriptor pointer of a skipped descriptor never alters the scan order.
// (RL5) Each skip map is 32 bits, one per descriptor, and resets to all ones so everything starts skipped.
// (RL6) Software should not set the skip bit at a position an active next-descriptor pointer names.
// (RL7) The descriptor whose last-map bit is set is the final one checked for a set valid flag.
// (RL8) After the last-marked descriptor the scan restarts at the category's first position.
// (RL9) The last map is a 32-bit bitmap: value 1h allows one descriptor, 2h allows two.
// (RL10) Software should put the last bit above every position named by an active next pointer.
// (RL11) With a zero last map all 32 positions are checked before wrapping to the first.
// (RL12) The highest set bit of the last map is taken as the final position.
`timescale 1ns/10ps
module dsm_maps (
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   // Register port
   input  wire logic [dsm_pkg::DSM_AW-1:0] addr_i,
   input  wire logic [dsm_pkg::DSM_DW-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [dsm_pkg::DSM_DW-1:0] rdata_o,
   // Isochronous engine
   input  wire logic [31:0]                iso_valid_i,
   input  wire logic                       iso_accept_i,
   input  wire logic                       iso_next_vld_i,
   input  wire logic [4:0]                 iso_next_ptr_i,
   input  wire logic                       iso_done_i,
   input  wire logic [4:0]                 iso_done_idx_i,
   output logic                            iso_issue_o,
   output logic      [4:0]                 iso_issue_idx_o,
   // Interrupt-category engine
   input  wire logic [31:0]                int_valid_i,
   input  wire logic                       int_accept_i,
   input  wire logic                       int_next_vld_i,
   input  wire logic [4:0]                 int_next_ptr_i,
   input  wire logic                       int_done_i,
   input  wire logic [4:0]                 int_done_idx_i,
   output logic                            int_issue_o,
   output logic      [4:0]                 int_issue_idx_o,
   // Interrupt
   output logic                            irq_o
);
   import dsm_pkg::*;

   // ---------------------------------------------------------------
   // Category arrays
   // ---------------------------------------------------------------
   logic [11:0]           ofs_done  [DSM_NCAT];
   logic [11:0]           ofs_skip  [DSM_NCAT];
   logic [11:0]           ofs_last  [DSM_NCAT];
   logic [31:0]           valid_a   [DSM_NCAT];
   logic [DSM_NCAT-1:0]   accept_a;
   logic [DSM_NCAT-1:0]   next_vld_a;
   logic [4:0]            next_ptr_a[DSM_NCAT];
   logic [DSM_NCAT-1:0]   done_ev_a;
   logic [4:0]            done_idx_a[DSM_NCAT];
   logic [DSM_NCAT-1:0]   issue_a;
   logic [4:0]            issue_idx_a[DSM_NCAT];
   logic [DSM_NCAT-1:0]   pass_a;
   logic [DSM_NCAT-1:0]   run_a;

   // Map registers, one entry per category
   logic [31:0]           done_r    [DSM_NCAT];
   logic [31:0]           done_nxt  [DSM_NCAT];
   logic [31:0]           skip_r    [DSM_NCAT];
   logic [31:0]           last_r    [DSM_NCAT];
   logic [DSM_NCAT-1:0]   rd_done_a;

   // Control and interrupt registers
   logic [1:0]            ctrl_r;
   logic [DSM_IRQ_W-1:0]  irq_sts_r;
   logic [DSM_IRQ_W-1:0]  irq_sts_nxt;
   logic [DSM_IRQ_W-1:0]  irq_en_r;
   logic [31:0]           rdata_r;

   // Offsets per category
   assign ofs_done[DSM_CAT_ISO] = DSM_OFS_ISO_DONE_MAP;
   assign ofs_done[DSM_CAT_INT] = DSM_OFS_INT_DONE_MAP;
   assign ofs_skip[DSM_CAT_ISO] = DSM_OFS_ISO_SKIP_MAP;
   assign ofs_skip[DSM_CAT_INT] = DSM_OFS_INT_SKIP_MAP;
   assign ofs_last[DSM_CAT_ISO] = DSM_OFS_ISO_LAST_MAP;
   assign ofs_last[DSM_CAT_INT] = DSM_OFS_INT_LAST_MAP;

   // Engine ports gathered by category
   assign valid_a[DSM_CAT_ISO]    = iso_valid_i;
   assign valid_a[DSM_CAT_INT]    = int_valid_i;
   assign accept_a                = {int_accept_i, iso_accept_i};
   assign next_vld_a              = {int_next_vld_i, iso_next_vld_i};
   assign next_ptr_a[DSM_CAT_ISO] = iso_next_ptr_i;
   assign next_ptr_a[DSM_CAT_INT] = int_next_ptr_i;
   assign done_ev_a               = {int_done_i, iso_done_i};
   assign done_idx_a[DSM_CAT_ISO] = iso_done_idx_i;
   assign done_idx_a[DSM_CAT_INT] = int_done_idx_i;

   // Engine outputs scattered back
   assign iso_issue_o     = issue_a[DSM_CAT_ISO];
   assign iso_issue_idx_o = issue_idx_a[DSM_CAT_ISO];
   assign int_issue_o     = issue_a[DSM_CAT_INT];
   assign int_issue_idx_o = issue_idx_a[DSM_CAT_INT];

   // ---------------------------------------------------------------
   // Per-category maps and scanner
   // ---------------------------------------------------------------
   for (genvar c = 0; c < DSM_NCAT; c++) begin : g_cat
      wire        wr_skip  = wr_i & (addr_i == ofs_skip[c]);
      wire        wr_last  = wr_i & (addr_i == ofs_last[c]);
      wire [31:0] done_set = done_ev_a[c] ? (32'h1 << done_idx_a[c]) : 32'h0; // [RL1]

      assign rd_done_a[c] = rd_i & (addr_i == ofs_done[c]);
      // A read empties the map, but a completion in the same cycle survives
      assign done_nxt[c]  = rd_done_a[c] ? done_set : (done_r[c] | done_set); // [RL2]

      // Done map
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            done_r[c] <= DSM_DONE_RST;
         end else begin
            done_r[c] <= done_nxt[c];
         end
      end

      // Skip map starts all ones, so nothing runs until software clears bits
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            skip_r[c] <= DSM_SKIP_RST;                  // [RL5]
         end else if (wr_skip) begin
            skip_r[c] <= wdata_i;
         end
      end

      // Last-descriptor map
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            last_r[c] <= DSM_LAST_RST;
         end else if (wr_last) begin
            last_r[c] <= wdata_i;                       // [RL9]
         end
      end

      dsm_scan #(
         .NDESC (DSM_NDESC),
         .IDXW  (DSM_IDXW)
      ) u_scan (
         .sys_clk_i   (sys_clk_i),
         .rst_b_i     (rst_b_i),
         .run_i       (ctrl_r[c]),
         .skip_i      (skip_r[c]),                      // [RL3]
         .last_i      (last_r[c]),                      // [RL7]
         .valid_i     (valid_a[c]),
         .accept_i    (accept_a[c]),
         .next_vld_i  (next_vld_a[c]),
         .next_ptr_i  (next_ptr_a[c]),
         .issue_o     (issue_a[c]),
         .issue_idx_o (issue_idx_a[c]),
         .running_o   (run_a[c]),
         .pass_o      (pass_a[c])
      );

      // Map checks
      a_done_bit_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL1]
         done_ev_a[c] |=> done_r[c][$past(done_idx_a[c])])
         else $error("completion did not set its done bit");

      a_done_read_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL2]
         rd_done_a[c] && !done_ev_a[c] |=> done_r[c] == 32'h0)
         else $error("done map not cleared by read");

      a_done_read_val: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL2]
         rd_done_a[c] |=> rdata_o == $past(done_r[c]))
         else $error("done map read returned wrong bits");

      a_skip_reset_ones: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL5]
         $past(!rst_b_i) |-> skip_r[c] == DSM_SKIP_RST)
         else $error("skip map did not reset to all ones");

      a_last_map_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL9]
         wr_last ##1 (!wr_last)[*2] |-> last_r[c] == $past(wdata_i, 2))
         else $error("last map lost its written value");
   end

   // ---------------------------------------------------------------
   // Control and interrupt registers
   // ---------------------------------------------------------------
   wire wr_ctrl    = wr_i & (addr_i == DSM_OFS_SCAN_CTRL);
   wire wr_irq_en  = wr_i & (addr_i == DSM_OFS_IRQ_ENABLE);
   wire wr_irq_clr = wr_i & (addr_i == DSM_OFS_IRQ_CLEAR);
   wire [DSM_IRQ_W-1:0] irq_set = {pass_a, done_ev_a};
   wire [DSM_IRQ_W-1:0] irq_clr = wr_irq_clr ? wdata_i[DSM_IRQ_W-1:0] : '0;

   // Set beats clear so an event in the clearing cycle is kept
   assign irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_set;

   // Scanner run bits
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= DSM_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wdata_i[1:0];
      end
   end

   // Sticky status
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_sts_r <= DSM_IRQ_RST;
      end else begin
         irq_sts_r <= irq_sts_nxt;
      end
   end

   // Interrupt enable
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_en_r <= DSM_IRQ_RST;
      end else if (wr_irq_en) begin
         irq_en_r <= wdata_i[DSM_IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_sts_r & irq_en_r);

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   wire [31:0] pos_word = {14'h0, run_a,
                           3'h0, issue_idx_a[DSM_CAT_INT],
                           3'h0, issue_idx_a[DSM_CAT_ISO]};

   // Unmapped and write-only addresses read as zero
   wire [31:0] rd_mux =
      (addr_i == DSM_OFS_ISO_DONE_MAP) ? done_r[DSM_CAT_ISO] :
      (addr_i == DSM_OFS_ISO_SKIP_MAP) ? skip_r[DSM_CAT_ISO] :
      (addr_i == DSM_OFS_ISO_LAST_MAP) ? last_r[DSM_CAT_ISO] :
      (addr_i == DSM_OFS_INT_DONE_MAP) ? done_r[DSM_CAT_INT] :
      (addr_i == DSM_OFS_INT_SKIP_MAP) ? skip_r[DSM_CAT_INT] :
      (addr_i == DSM_OFS_INT_LAST_MAP) ? last_r[DSM_CAT_INT] :
      (addr_i == DSM_OFS_SCAN_CTRL)    ? {30'h0, ctrl_r} :
      (addr_i == DSM_OFS_SCAN_POS)     ? pos_word :
      (addr_i == DSM_OFS_IRQ_STATUS)   ? {28'h0, irq_sts_r} :
      (addr_i == DSM_OFS_IRQ_ENABLE)   ? {28'h0, irq_en_r} :
                                         32'h0;

   // Data stand for one cycle after the strobe only
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= rd_i ? rd_mux : 32'h0;
      end
   end

   assign rdata_o = rdata_r;

   // ---------------------------------------------------------------
   // Interrupt checks
   // ---------------------------------------------------------------
   a_irq_event_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_ev_a[DSM_CAT_ISO] && irq_en_r[DSM_IRQ_DONE_LSB] && !wr_irq_en |=> irq_o)
      else $error("done event did not raise the interrupt");

endmodule

//--- verification/tb_top.sv
/*
 Self-checking bench for dsm_maps: register bus, done maps, scanners, interrupt.
 Assumes one 25 MHz clock and a bench-side cycle model of both scanners.
*/
`timescale 1ns/10ps
module tb_top;
   import dsm_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        sys_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic [11:0] addr_i    = 12'h000;
   logic [31:0] wdata_i   = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic [31:0] rdata_o;
   logic [31:0] valid [2] = '{32'h0, 32'h0};
   logic [4:0]  ptr [2]   = '{5'h0, 5'h0};
   logic [4:0]  didx [2]  = '{5'h0, 5'h0};
   logic [4:0]  iidx [2];
   logic [1:0]  acc = 2'h0, nv = 2'h0, done = 2'h0, issue;
   logic        irq_o, scan_on = 1'b0;
   logic [31:0] seed = 32'd88899, m_skip [2], m_last [2], e, sk [5], la [5];
   logic [4:0]  m_pos [2], p, idx;
   logic [1:0]  m_run, m_ctrl;
   int          n_fail = 0, checked = 0;
   dsm_maps dsm_maps_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .iso_valid_i(valid[0]), .iso_accept_i(acc[0]),
      .iso_next_vld_i(nv[0]), .iso_next_ptr_i(ptr[0]), .iso_done_i(done[0]), .iso_done_idx_i(didx[0]),
      .iso_issue_o(issue[0]), .iso_issue_idx_o(iidx[0]), .int_valid_i(valid[1]), .int_accept_i(acc[1]),
      .int_next_vld_i(nv[1]), .int_next_ptr_i(ptr[1]), .int_done_i(done[1]), .int_done_idx_i(didx[1]),
      .int_issue_o(issue[1]), .int_issue_idx_o(iidx[1]), .irq_o(irq_o));
   // Clock, 40 ns period
   always #20 sys_clk_i = ~sys_clk_i;
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Final position: highest set bit, 31 when the map is empty
   function automatic logic [4:0] fin(input logic [31:0] l);
      fin = 5'h1f;
      for (int i = 0; i < 32; i++) begin
         if (l[i]) begin
            fin = i[4:0];
         end
      end
   endfunction
   function automatic logic elig(input int c);
      return m_run[c] && valid[c][m_pos[c]] && !m_skip[c][m_pos[c]];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(rdata_o, exp);
   endtask
   task automatic pulse(input int c, input logic [4:0] i);
      @(posedge sys_clk_i);
      done[c] <= 1'b1;
      didx[c] <= i;
      @(posedge sys_clk_i);
      done[c] <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scanner model and checking
   // ---------------------------------------------------------------
   // Mirrors the flops: reads pre-edge inputs, then picks up register writes
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         m_run = 2'h0;
         m_ctrl = 2'h0;
         m_skip = '{32'hffff_ffff, 32'hffff_ffff};
         m_last = '{32'h0, 32'h0};
         m_pos = '{5'h0, 5'h0};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (!m_run[c]) begin
               m_pos[c] = 5'h0;
            end else if (!elig(c) || acc[c]) begin
               m_pos[c] = (m_pos[c] == fin(m_last[c])) ? 5'h0 : (elig(c) && nv[c]) ? ptr[c] : m_pos[c] + 5'h1;
            end
            if (wr_i && addr_i == DSM_OFS_ISO_SKIP_MAP + 12'(c * 16)) begin
               m_skip[c] = wdata_i;
            end
            if (wr_i && addr_i == DSM_OFS_ISO_LAST_MAP + 12'(c * 16)) begin
               m_last[c] = wdata_i;
            end
         end
         // The scanner state follows the run bits one edge later
         m_run = m_ctrl;
         if (wr_i && addr_i == DSM_OFS_SCAN_CTRL) begin
            m_ctrl = wdata_i[1:0];
         end
      end
   end
   // Compare offers and position once outputs have settled
   always @(negedge sys_clk_i) begin
      if (rst_b_i) begin
         for (int c = 0; c < 2; c++) begin
            chk({31'h0, issue[c]}, {31'h0, elig(c)});
            chk({27'h0, iidx[c]}, {27'h0, m_pos[c]});
         end
      end
   end
   // Random engine traffic; pointers stay below the final position and off skipped ones
   always @(posedge sys_clk_i) begin
      if (scan_on) begin
         for (int c = 0; c < 2; c++) begin
            p = 5'(rnd() % (32'(fin(m_last[c])) + 1));
            valid[c] <= rnd() | rnd();
            acc[c] <= rnd() % 3 != 0;
            nv[c] <= (rnd() % 2 == 1) && p != fin(m_last[c]) && !m_skip[c][p];
            ptr[c] <= p;
         end
      end
   end
   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      sk = '{32'hffff_fffc, 32'hffff_fffe, 32'h7fff_ffff, 32'h0, 32'h0};
      la = '{32'h2, 32'h1, 32'h0, 32'h3, 32'h0};
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         rd_chk(DSM_OFS_ISO_SKIP_MAP + 12'(c * 16), 32'hffff_ffff);
         rd_chk(DSM_OFS_ISO_LAST_MAP + 12'(c * 16), 32'h0);
         rd_chk(DSM_OFS_ISO_DONE_MAP + 12'(c * 16), 32'h0);
      end
      rd_chk(12'h0fc, 32'h0);
      // Done maps: random completions, a completion at the clearing edge
      for (int c = 0; c < 2; c++) begin
         e = 32'h0;
         for (int k = 0; k < 6; k++) begin
            idx = 5'(rnd());
            e[idx] = 1'b1;
            pulse(c, idx);
         end
         @(posedge sys_clk_i);
         rd_i <= 1'b1;
         addr_i <= DSM_OFS_ISO_DONE_MAP + 12'(c * 16);
         done[c] <= 1'b1;
         didx[c] <= 5'h7;
         @(posedge sys_clk_i);
         rd_i <= 1'b0;
         done[c] <= 1'b0;
         @(negedge sys_clk_i);
         chk(rdata_o, e);
         rd_chk(DSM_OFS_ISO_DONE_MAP + 12'(c * 16), 32'h80);
         rd_chk(DSM_OFS_ISO_DONE_MAP + 12'(c * 16), 32'h0);
      end
      // Scanners under a table of skip and last settings
      scan_on = 1'b1;
      sk[4] = rnd();
      la[4] = rnd() & 32'h0000_ffff;
      wr(DSM_OFS_SCAN_CTRL, 32'h3);
      for (int t = 0; t < 5; t++) begin
         for (int c = 0; c < 2; c++) begin
            wr(DSM_OFS_ISO_SKIP_MAP + 12'(c * 16), sk[t]);
            wr(DSM_OFS_ISO_LAST_MAP + 12'(c * 16), la[t]);
            rd_chk(DSM_OFS_ISO_SKIP_MAP + 12'(c * 16), sk[t]);
            rd_chk(DSM_OFS_ISO_LAST_MAP + 12'(c * 16), la[t]);
         end
         repeat (90) @(posedge sys_clk_i);
      end
      wr(DSM_OFS_SCAN_CTRL, 32'h1);
      repeat (20) @(posedge sys_clk_i);
      wr(DSM_OFS_SCAN_CTRL, 32'h0);
      scan_on = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      // Interrupt: raise, clear, mask
      wr(DSM_OFS_IRQ_CLEAR, 32'hf);
      wr(DSM_OFS_IRQ_ENABLE, 32'h1);
      rd_chk(DSM_OFS_IRQ_STATUS, 32'h0);
      pulse(0, 5'h3);
      repeat (2) @(negedge sys_clk_i);
      chk({31'h0, irq_o}, 32'h1);
      rd_chk(DSM_OFS_IRQ_STATUS, 32'h1);
      wr(DSM_OFS_IRQ_CLEAR, 32'h1);
      @(negedge sys_clk_i);
      chk({31'h0, irq_o}, 32'h0);
      wr(DSM_OFS_IRQ_ENABLE, 32'h0);
      pulse(1, 5'h9);
      repeat (2) @(negedge sys_clk_i);
      chk({31'h0, irq_o}, 32'h0);
      rd_chk(DSM_OFS_IRQ_STATUS, 32'h2);
      rd_chk(DSM_OFS_INT_DONE_MAP, 32'h200);
      end_of_test();
   end
endmodule
